/* File: logic/pmhc_regs.svh */
// Register offsets, field positions, reset values and codes for the data-link control block
// What this block does
// - Count each abort sequence (seven ones) detected with receive enabled in C-bit parity format in a 16-bit saturating counter.
// - Software reads low byte at counter, then high byte at 3EH immediately after.
// - Abort counter frozen during DS3 loss of signal, out of frame, AIS or idle.
// - Reading the counter clears it; an abort in that read cycle is still counted.
// - On saturation, raise the abort-saturation request for the register at 2BH.
// - Polarity bit 6 at 1 drives interrupt pin active low, else active high.
// - Receive half-full enable at 1: state 010 on FIFO half full or end of message.
// - Receive half-full enable at 0: interrupt only on FIFO full/overflow or end of message.
// - Receive enable bit 4 passes destuffed C-bit parity bytes into the FIFO read at 38H.
// - Clearing receive enable disables the receiver and suppresses all its interrupts.
// - Software sets end-of-message bit 2; after drain, device sends FCS, then clears it.
// - Transmit half-full enable at 1: interrupt on crossing to half empty or end of message.
// - Transmit half-full enable at 0: interrupt only at end of message or underflow.
// - Reading a counter low byte copies its high byte into the common register and holds it.
// - Transmitter enabled with empty FIFO sends HDLC flags on the data-link C-bits.
`ifndef PMHC_REGS_SVH
`define PMHC_REGS_SVH

`define PMHC_ADDR_ABORT_LO 6'h3C
`define PMHC_ADDR_CTRL 6'h3D
`define PMHC_ADDR_HIGH_LATCH 6'h3E

`define PMHC_BIT_TX_EN 0
`define PMHC_BIT_TX_HALF_FULL_IRQ_ENABLE 1
`define PMHC_BIT_EOM 2
`define PMHC_BIT_RSVD 3
`define PMHC_BIT_RX_EN 4
`define PMHC_BIT_RX_HALF_FULL_IRQ_ENABLE 5
`define PMHC_BIT_IPOL 6

`define PMHC_CTRL_RESET 8'h00
`define PMHC_COUNT_RESET 16'h0000
`define PMHC_LATCH_RESET 8'h00

`define PMHC_RXIRQ_NONE 3'h0
`define PMHC_RXIRQ_EOM 3'h1
`define PMHC_RXIRQ_FILL 3'h2

`endif

/* File: logic/pmhc_pkg.sv */
// Types shared by the data-link control block
package pmhc_pkg;
  typedef enum logic [0:0] {
    TX_RUN,
    TX_FCS
  } pmhc_tx_state_t;
endpackage : pmhc_pkg

/* File: logic/pmhc_buf2.sv */
// Two-entry buffer between the destuffer and the receive FIFO
`timescale 1ns/10ps
`default_nettype none
module pmhc_buf2
  import pmhc_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Filling side
  input wire logic s_valid,
  input wire logic [W-1:0] s_data,
  output logic s_ready,
  // Draining side
  output logic m_valid,
  output logic [W-1:0] m_data,
  input wire logic m_ready
);
  logic [W-1:0] mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  wire push = s_valid && s_ready;
  wire pop = m_valid && m_ready;

  assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  assign m_data = mem_r[rd_ptr_r];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
      s_ready <= 1'b1;
      m_valid <= 1'b0;
    end else begin
      if (push) wr_ptr_r <= ~wr_ptr_r;
      if (pop) rd_ptr_r <= ~rd_ptr_r;
      cnt_r <= cnt_nxt;
      s_ready <= cnt_nxt != 2'h2;
      m_valid <= cnt_nxt != 2'h0;
    end
  end

  // Storage needs no reset; valid guards it
  always_ff @(posedge clock) begin
    if (push) mem_r[wr_ptr_r] <= s_data;
  end
endmodule : pmhc_buf2
`default_nettype wire

/* File: logic/pmhc_abort_cnt.sv */
// Saturating 16-bit abort counter, cleared by a processor read
`timescale 1ns/10ps
`default_nettype none
`include "pmhc_regs.svh"
module pmhc_abort_cnt
  import pmhc_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Events
  input wire logic inc,
  input wire logic inhibit,
  input wire logic clr,
  // State
  output logic [W-1:0] count,
  output logic sat_pulse
);
  localparam logic [W-1:0] ALL_ONES = {W{1'b1}};
  wire do_inc = inc && !inhibit;
  wire at_max = count == ALL_ONES;
  logic [W-1:0] count_nxt;

  // A read clears; an abort in the same cycle becomes the first count
  assign count_nxt = clr ? (do_inc ? W'(1) : '0)
                   : (do_inc && !at_max) ? count + W'(1)
                   : count;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= `PMHC_COUNT_RESET;
      sat_pulse <= 1'b0;
    end else begin
      count <= count_nxt;
      sat_pulse <= (count_nxt == ALL_ONES) && !at_max;
    end
  end

  chk_hold_at_max: assert property (@(posedge clock) disable iff (rst)
    at_max && !clr |=> at_max) else $error("saturated counter moved without a read");
  chk_read_keeps_event: assert property (@(posedge clock) disable iff (rst)
    clr && inc && !inhibit |=> count == W'(1)) else $error("abort lost in read cycle");
  chk_inhibit_freeze: assert property (@(posedge clock) disable iff (rst)
    inhibit && !clr |=> $stable(count)) else $error("counter moved while inhibited");
  chk_count_step: assert property (@(posedge clock) disable iff (rst)
    inc && !inhibit && !clr && !at_max |=> count == $past(count) + W'(1))
    else $error("abort not counted");
  chk_sat_once: assert property (@(posedge clock) disable iff (rst)
    sat_pulse |=> !sat_pulse) else $error("saturation pulse longer than a cycle");
endmodule : pmhc_abort_cnt
`default_nettype wire

/* File: logic/pmhc_ctrl.sv */
// Data-link control register, abort counter access and interrupt condition logic
`timescale 1ns/10ps
`default_nettype none
`include "pmhc_regs.svh"
module pmhc_ctrl
  import pmhc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Processor register port
  input wire logic [5:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  // DS3 alarms and framing mode
  input wire logic ds3_los,
  input wire logic ds3_oof,
  input wire logic ds3_ais,
  input wire logic ds3_idle,
  input wire logic frame_format_select,
  // Receive path from the destuffer
  input wire logic abort_detect,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_byte_ready,
  // Receive FIFO write port
  output logic rx_fifo_wr_valid,
  output logic [7:0] rx_fifo_wr_data,
  input wire logic rx_fifo_wr_ready,
  // Receive FIFO status
  input wire logic rx_fifo_half,
  input wire logic rx_fifo_full_ovf,
  input wire logic rx_eom_detect,
  // Transmit FIFO status and FCS handshake
  input wire logic tx_fifo_empty,
  input wire logic tx_half_cross,
  input wire logic tx_underflow,
  input wire logic tx_fcs_done,
  output logic tx_send_fcs,
  output logic tx_send_flags,
  // Control levels for the datapath
  output logic rx_hdlc_enable,
  output logic tx_hdlc_enable,
  output logic tx_last_byte_flag,
  // Interrupt requests and pin
  output logic [2:0] rx_hdlc_irq_state,
  output logic tx_hdlc_irq_request,
  output logic abort_saturation_irq,
  input wire logic irq_active,
  output logic irq_pin
);
  // Control register fields
  logic tx_en_r;
  logic tx_half_full_irq_enable_r;
  logic eom_r;
  logic rx_en_r;
  logic rx_half_full_irq_enable_r;
  logic ipol_r;
  logic [7:0] high_latch_r;
  pmhc_tx_state_t tx_state_r;
  pmhc_tx_state_t tx_state_nxt;

  // Decode
  wire sel_abort = bus_addr == `PMHC_ADDR_ABORT_LO;
  wire sel_ctrl = bus_addr == `PMHC_ADDR_CTRL;
  wire sel_high = bus_addr == `PMHC_ADDR_HIGH_LATCH;
  wire rd_abort = bus_rd && sel_abort;
  wire wr_ctrl = bus_wr && sel_ctrl;
  wire ds3_alarm = ds3_los || ds3_oof || ds3_ais || ds3_idle;
  // Aborts only exist in C-bit parity frames with the receiver on
  wire abort_in = abort_detect && rx_en_r && !frame_format_select;

  logic [15:0] abort_count;
  logic abort_sat;

  pmhc_abort_cnt #(
    .W(16)
  ) u_abort (
    .clock(clock),
    .rst(rst),
    .inc(abort_in),
    .inhibit(ds3_alarm),
    .clr(rd_abort),
    .count(abort_count),
    .sat_pulse(abort_sat)
  );

  // Receive bytes pass through only while enabled and in C-bit parity format
  wire rx_pass = rx_en_r && !frame_format_select;
  logic buf_s_ready;

  pmhc_buf2 #(
    .W(8)
  ) u_rxbuf (
    .clock(clock),
    .rst(rst),
    .s_valid(rx_byte_valid && rx_pass),
    .s_data(rx_byte),
    .s_ready(buf_s_ready),
    .m_valid(rx_fifo_wr_valid),
    .m_data(rx_fifo_wr_data),
    .m_ready(rx_fifo_wr_ready)
  );

  // Ready stays high while disabled so the destuffer drains instead of stalling
  assign rx_byte_ready = buf_s_ready || !rx_pass;

  // Read data; the high byte is captured in the same edge that clears the counter
  wire [7:0] ctrl_view = {1'b0, ipol_r, rx_half_full_irq_enable_r, rx_en_r, 1'b0, eom_r, tx_half_full_irq_enable_r, tx_en_r};
  wire [7:0] rdata_nxt = sel_abort ? abort_count[7:0]
                       : sel_ctrl ? ctrl_view
                       : sel_high ? high_latch_r
                       : 8'h00;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      bus_rdata <= rdata_nxt;
    end
  end

  // Copying at the clearing edge keeps both bytes from one instant
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      high_latch_r <= `PMHC_LATCH_RESET;
    end else if (rd_abort) begin
      high_latch_r <= abort_count[15:8];
    end
  end

  // End of message: wait for the FIFO to drain, send FCS, then clear
  wire eom_drained = eom_r && tx_en_r && tx_fifo_empty && tx_state_r == TX_RUN;
  wire eom_finish = tx_state_r == TX_FCS && tx_fcs_done;
  always_comb begin
    tx_state_nxt = tx_state_r;
    unique case (tx_state_r)
      TX_RUN: if (eom_drained) tx_state_nxt = TX_FCS;
      TX_FCS: if (eom_finish || !tx_en_r) tx_state_nxt = TX_RUN;
    endcase
  end

  // Reserved bit 3 is not stored and reads back as zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {ipol_r, rx_half_full_irq_enable_r, rx_en_r, tx_half_full_irq_enable_r, tx_en_r} <= 5'h00;
    end else if (wr_ctrl) begin
      ipol_r <= bus_wdata[`PMHC_BIT_IPOL];
      rx_half_full_irq_enable_r <= bus_wdata[`PMHC_BIT_RX_HALF_FULL_IRQ_ENABLE];
      rx_en_r <= bus_wdata[`PMHC_BIT_RX_EN];
      tx_half_full_irq_enable_r <= bus_wdata[`PMHC_BIT_TX_HALF_FULL_IRQ_ENABLE];
      tx_en_r <= bus_wdata[`PMHC_BIT_TX_EN];
    end
  end

  // A software set in the finishing cycle wins over the self clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      eom_r <= 1'b0;
    end else if (wr_ctrl && bus_wdata[`PMHC_BIT_EOM]) begin
      eom_r <= 1'b1;
    end else if (eom_finish || !tx_en_r) begin
      eom_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_state_r <= TX_RUN;
    end else begin
      tx_state_r <= tx_state_nxt;
    end
  end

  // Interrupt conditions
  wire rx_fill = rx_half_full_irq_enable_r ? rx_fifo_half : rx_fifo_full_ovf;
  wire [2:0] rx_state_nxt = !rx_en_r ? `PMHC_RXIRQ_NONE
                          : (rx_fill || (rx_half_full_irq_enable_r && rx_eom_detect)) ? `PMHC_RXIRQ_FILL
                          : rx_eom_detect ? `PMHC_RXIRQ_EOM
                          : `PMHC_RXIRQ_NONE;
  wire tx_irq_nxt = tx_en_r && (eom_finish || (tx_half_full_irq_enable_r ? tx_half_cross : tx_underflow));

  // Interrupt requests
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_hdlc_irq_state <= `PMHC_RXIRQ_NONE;
      tx_hdlc_irq_request <= 1'b0;
      abort_saturation_irq <= 1'b0;
    end else begin
      rx_hdlc_irq_state <= rx_state_nxt;
      tx_hdlc_irq_request <= tx_irq_nxt;
      abort_saturation_irq <= abort_sat;
    end
  end

  // Polarity applied before the flop so the pin never glitches
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_pin <= 1'b0;
    end else begin
      irq_pin <= irq_active ^ ipol_r;
    end
  end

  // Transmit line requests
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_send_fcs <= 1'b0;
      tx_send_flags <= 1'b0;
    end else begin
      tx_send_fcs <= eom_drained;
      tx_send_flags <= tx_en_r && tx_fifo_empty && !eom_r && tx_state_r == TX_RUN;
    end
  end

  // Control levels lag the register by one cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_hdlc_enable <= 1'b0;
      tx_hdlc_enable <= 1'b0;
      tx_last_byte_flag <= 1'b0;
    end else begin
      rx_hdlc_enable <= rx_en_r;
      tx_hdlc_enable <= tx_en_r;
      tx_last_byte_flag <= eom_r;
    end
  end

  chk_pin_polarity: assert property (@(posedge clock) disable iff (rst)
    ##1 irq_pin == ($past(irq_active) ^ $past(ipol_r))) else $error("interrupt pin polarity wrong");
  chk_high_latch: assert property (@(posedge clock) disable iff (rst)
    rd_abort |=> high_latch_r == $past(abort_count[15:8])) else $error("high byte not latched");
  chk_low_read: assert property (@(posedge clock) disable iff (rst)
    rd_abort |=> bus_rdata == $past(abort_count[7:0])) else $error("low byte read wrong");
  chk_rx_quiet: assert property (@(posedge clock) disable iff (rst)
    !rx_en_r |=> rx_hdlc_irq_state == `PMHC_RXIRQ_NONE) else $error("receive irq while disabled");
  chk_rx_half: assert property (@(posedge clock) disable iff (rst)
    rx_en_r && rx_half_full_irq_enable_r && rx_fifo_half |=> rx_hdlc_irq_state == `PMHC_RXIRQ_FILL)
    else $error("half full not signalled");
  chk_rx_nohalf: assert property (@(posedge clock) disable iff (rst)
    rx_en_r && !rx_half_full_irq_enable_r && rx_fifo_half && !rx_fifo_full_ovf && !rx_eom_detect
    |=> rx_hdlc_irq_state == `PMHC_RXIRQ_NONE) else $error("half full signalled while off");
  chk_tx_irq_mode: assert property (@(posedge clock) disable iff (rst)
    tx_en_r && !tx_half_full_irq_enable_r && tx_half_cross && !tx_underflow && !eom_finish
    |=> !tx_hdlc_irq_request) else $error("transmit half irq while off");
  chk_tx_half: assert property (@(posedge clock) disable iff (rst)
    tx_en_r && tx_half_full_irq_enable_r && tx_half_cross |=> tx_hdlc_irq_request) else $error("half cross missed");
  chk_eom_clear: assert property (@(posedge clock) disable iff (rst)
    eom_finish && !(wr_ctrl && bus_wdata[`PMHC_BIT_EOM]) |=> !eom_r ##1 !tx_last_byte_flag)
    else $error("end of message bit not cleared after FCS");
  chk_flags_idle: assert property (@(posedge clock) disable iff (rst)
    tx_en_r && tx_fifo_empty && !eom_r && tx_state_r == TX_RUN |=> tx_send_flags)
    else $error("no flags while idle");

  // Register port, pin and saturation request
  chk_high_read: assert property (@(posedge clock) disable iff (rst)
    bus_rd && sel_high |=> bus_rdata == $past(high_latch_r))
    else $error("high latch read wrong");
  chk_rdata_hold: assert property (@(posedge clock) disable iff (rst)
    !bus_rd |=> $stable(bus_rdata)) else $error("read data moved without a read");
  chk_latch_hold: assert property (@(posedge clock) disable iff (rst)
    !rd_abort |=> $stable(high_latch_r)) else $error("high latch moved without a read");
  chk_pin_low: assert property (@(posedge clock) disable iff (rst)
    ipol_r && irq_active |=> !irq_pin) else $error("active low pin not low");
  chk_pin_high: assert property (@(posedge clock) disable iff (rst)
    !ipol_r && irq_active |=> irq_pin) else $error("active high pin not high");
  chk_sat_irq: assert property (@(posedge clock) disable iff (rst)
    abort_sat |=> abort_saturation_irq) else $error("saturation request missed");

  // Receive side
  chk_rx_enable_out: assert property (@(posedge clock) disable iff (rst)
    ##1 rx_hdlc_enable == $past(rx_en_r)) else $error("receive enable level wrong");
  chk_rx_gate: assert property (@(posedge clock) disable iff (rst)
    !rx_fifo_wr_valid && !(rx_byte_valid && rx_pass) |=> !rx_fifo_wr_valid)
    else $error("receive byte appeared from nowhere");
  chk_rx_eom_only: assert property (@(posedge clock) disable iff (rst)
    rx_en_r && !rx_half_full_irq_enable_r && rx_eom_detect && !rx_fifo_full_ovf
    |=> rx_hdlc_irq_state == `PMHC_RXIRQ_EOM) else $error("end of message not signalled");
  chk_rx_full: assert property (@(posedge clock) disable iff (rst)
    rx_en_r && !rx_half_full_irq_enable_r && rx_fifo_full_ovf |=> rx_hdlc_irq_state == `PMHC_RXIRQ_FILL)
    else $error("full not signalled");
  chk_rx_eom_fill: assert property (@(posedge clock) disable iff (rst)
    rx_en_r && rx_half_full_irq_enable_r && rx_eom_detect |=> rx_hdlc_irq_state == `PMHC_RXIRQ_FILL)
    else $error("end of message not in fill state");

  // Transmit side
  chk_tx_unf: assert property (@(posedge clock) disable iff (rst)
    tx_en_r && !tx_half_full_irq_enable_r && tx_underflow |=> tx_hdlc_irq_request)
    else $error("underflow irq missed");
  chk_tx_half_only: assert property (@(posedge clock) disable iff (rst)
    tx_en_r && tx_half_full_irq_enable_r && tx_underflow && !tx_half_cross && !eom_finish
    |=> !tx_hdlc_irq_request) else $error("underflow irq in half mode");
  chk_eom_irq: assert property (@(posedge clock) disable iff (rst)
    tx_en_r && eom_finish |=> tx_hdlc_irq_request) else $error("end of message irq missed");
  chk_fcs_start: assert property (@(posedge clock) disable iff (rst)
    eom_drained |=> tx_send_fcs) else $error("FCS not started");
  chk_fcs_wait: assert property (@(posedge clock) disable iff (rst)
    !eom_r || !tx_fifo_empty |=> !tx_send_fcs) else $error("FCS started too early");
  chk_eom_hold: assert property (@(posedge clock) disable iff (rst)
    eom_r && tx_en_r && !eom_finish |=> eom_r)
    else $error("end of message bit cleared early");
  chk_flags_stop: assert property (@(posedge clock) disable iff (rst)
    !tx_en_r |=> !tx_send_flags) else $error("flags while transmitter off");
endmodule : pmhc_ctrl
`default_nettype wire

/* File: verification/pmhc_fifo_model.sv */
// Receive FIFO write-side model: prompt, slow or blocked acceptance
`timescale 1ns/10ps
`default_nettype none
module pmhc_fifo_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Write port from the block
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  // Mode: 0 prompt, 1 every other cycle, 2 blocked
  input wire logic [1:0] mode
);
  logic [7:0] got[$];
  logic phase_r;
  assign wr_ready = (mode == 2'h0) || (mode == 2'h1 && phase_r);
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
      if (wr_valid && wr_ready) got.push_back(wr_data);
    end
  end
endmodule : pmhc_fifo_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the data-link control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock, rst, bus_wr, bus_rd, ffs, abort_detect, rx_byte_valid, fifo_rdy, irq_active;
  logic rx_half, rx_full, rx_eom, tx_empty, tx_half, tx_unf, tx_done;
  logic rx_rdy, wr_valid, fcs, flags, rx_en, tx_en, last, tx_irq, sat, irq_pin;
  logic [5:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, rx_byte, wr_data, rd_v;
  logic [3:0] alarms;
  logic [2:0] rx_state;
  logic [1:0] mode;
  int n_errors, tests_run, n_sat, n_txirq, n_fcs, n0, f0;
  pmhc_ctrl uut (.clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ds3_los(alarms[0]),
    .ds3_oof(alarms[1]), .ds3_ais(alarms[2]), .ds3_idle(alarms[3]),
    .frame_format_select(ffs), .abort_detect(abort_detect), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .rx_byte_ready(rx_rdy), .rx_fifo_wr_valid(wr_valid),
    .rx_fifo_wr_data(wr_data), .rx_fifo_wr_ready(fifo_rdy), .rx_fifo_half(rx_half),
    .rx_fifo_full_ovf(rx_full), .rx_eom_detect(rx_eom), .tx_fifo_empty(tx_empty),
    .tx_half_cross(tx_half), .tx_underflow(tx_unf), .tx_fcs_done(tx_done),
    .tx_send_fcs(fcs), .tx_send_flags(flags), .rx_hdlc_enable(rx_en),
    .tx_hdlc_enable(tx_en), .tx_last_byte_flag(last), .rx_hdlc_irq_state(rx_state),
    .tx_hdlc_irq_request(tx_irq), .abort_saturation_irq(sat), .irq_active(irq_active),
    .irq_pin(irq_pin));
  pmhc_fifo_model fm (.clock(clock), .rst(rst), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ready(fifo_rdy), .mode(mode));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Pulse outputs are flops, so the pre-edge value is the settled one
  always @(posedge clock) begin
    if (sat === 1'b1) n_sat++;
    if (tx_irq === 1'b1) n_txirq++;
    if (fcs === 1'b1) n_fcs++;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic ab);
    @(posedge clock);
    bus_addr <= a;
    bus_rd <= 1'b1;
    abort_detect <= ab;
    @(posedge clock);
    bus_rd <= 1'b0;
    abort_detect <= 1'b0;
    #1;
    rd_v = bus_rdata;
  endtask : rd
  task automatic aborts(input int n);
    @(posedge clock);
    abort_detect <= 1'b1;
    repeat (n) @(posedge clock);
    abort_detect <= 1'b0;
  endtask : aborts
  // Holds the byte until ready is seen at a falling edge, then returns after the next rising edge takes it; caller drops valid
  task automatic send(input logic [7:0] b);
    int i;
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    for (i = 0; i < 20; i++) begin
      @(negedge clock);
      if (rx_rdy === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      report_and_stop();
    end
    @(posedge clock);
  endtask : send
  task automatic t_regs();
    rd(6'h3D, 1'b0);
    chk("ctrl reset", rd_v, 8'h00);
    rd(6'h20, 1'b0);
    chk("unmapped", rd_v, 8'h00);
    wr(6'h3D, 8'hF3);
    rd(6'h3D, 1'b0);
    chk("ctrl", rd_v, 8'h73);
    chk("rx enable", rx_en, 1'b1);
    @(posedge clock);
    tx_empty <= 1'b1;
    tick(3);
    chk("flags", flags, 1'b1);
    chk("tx enable", tx_en, 1'b1);
  endtask : t_regs
  task automatic t_abort();
    wr(6'h3D, 8'h10);
    aborts(3);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      alarms <= 4'h1 << i;
      aborts(1);
      @(posedge clock);
      alarms <= 4'h0;
    end
    rd(6'h3C, 1'b1);
    chk("abort low", rd_v, 8'h03);
    rd(6'h3E, 1'b0);
    chk("abort high", rd_v, 8'h00);
    rd(6'h3C, 1'b0);
    chk("abort in read", rd_v, 8'h01);
  endtask : t_abort
  task automatic t_sat();
    aborts(65536);
    tick(3);
    chk("sat pulses", 16'(n_sat), 16'h0001);
    rd(6'h3C, 1'b0);
    chk("sat low", rd_v, 8'hFF);
    aborts(5);
    rd(6'h3E, 1'b0);
    chk("latched high", rd_v, 8'hFF);
    rd(6'h3C, 1'b0);
    chk("after clear", rd_v, 8'h05);
    rd(6'h3E, 1'b0);
    chk("new high", rd_v, 8'h00);
  endtask : t_sat
  task automatic t_pin(input logic [7:0] c, input logic act, input logic exp);
    wr(6'h3D, c);
    irq_active <= act;
    tick(3);
    chk("irq pin", irq_pin, exp);
  endtask : t_pin
  task automatic t_rxirq(input logic [7:0] c, input logic [2:0] v, input logic [2:0] exp);
    wr(6'h3D, c);
    {rx_half, rx_full, rx_eom} <= v;
    tick(3);
    chk("rx irq state", rx_state, exp);
    @(posedge clock);
    {rx_half, rx_full, rx_eom} <= 3'h0;
    tick(3);
  endtask : t_rxirq
  task automatic t_txirq(input logic [7:0] c, input logic unf, input int exp);
    wr(6'h3D, c);
    tick(2);
    n0 = n_txirq;
    @(posedge clock);
    tx_unf <= unf;
    tx_half <= ~unf;
    @(posedge clock);
    tx_unf <= 1'b0;
    tx_half <= 1'b0;
    tick(4);
    chk("tx irq count", 16'(n_txirq - n0), 16'(exp));
  endtask : t_txirq
  task automatic t_eom();
    n0 = n_txirq;
    f0 = n_fcs;
    wr(6'h3D, 8'h05);
    tick(4);
    chk("fcs starts", 16'(n_fcs - f0), 16'h0001);
    chk("last flag", last, 1'b1);
    rd(6'h3D, 1'b0);
    chk("eom held", rd_v, 8'h05);
    @(posedge clock);
    tx_done <= 1'b1;
    @(posedge clock);
    tx_done <= 1'b0;
    tick(3);
    rd(6'h3D, 1'b0);
    chk("eom cleared", rd_v, 8'h01);
    chk("eom irq", 16'(n_txirq - n0), 16'h0001);
  endtask : t_eom
  task automatic t_rxdata();
    wr(6'h3D, 8'h10);
    mode <= 2'h2;
    send(8'hA1);
    send(8'hA2);
    rx_byte <= 8'hA3;
    tick(3);
    chk("full refuses", rx_rdy, 1'b0);
    @(posedge clock);
    mode <= 2'h1;
    send(8'hA3);
    send(8'hA4);
    send(8'hA5);
    ffs <= 1'b1;
    send(8'hB0);
    rx_byte_valid <= 1'b0;
    ffs <= 1'b0;
    wr(6'h3D, 8'h00);
    send(8'hB1);
    rx_byte_valid <= 1'b0;
    tick(10);
    chk("bytes kept", 16'(fm.got.size()), 16'h0005);
    foreach (fm.got[i]) chk("byte", fm.got[i], 8'hA1 + 8'(i));
  endtask : t_rxdata
  initial begin
    {rst, bus_wr, bus_rd, ffs, abort_detect, rx_byte_valid, irq_active} = 7'h40;
    {rx_half, rx_full, rx_eom, tx_empty, tx_half, tx_unf, tx_done} = 7'h00;
    {bus_addr, bus_wdata, rx_byte, alarms, mode} = 28'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_abort();
    t_sat();
    t_pin(8'h00, 1'b1, 1'b1);
    t_pin(8'h40, 1'b1, 1'b0);
    t_pin(8'h40, 1'b0, 1'b1);
    t_rxirq(8'h30, 3'h4, 3'h2);
    t_rxirq(8'h30, 3'h1, 3'h2);
    t_rxirq(8'h10, 3'h4, 3'h0);
    t_rxirq(8'h10, 3'h2, 3'h2);
    t_rxirq(8'h10, 3'h1, 3'h1);
    t_rxirq(8'h20, 3'h2, 3'h0);
    t_txirq(8'h03, 1'b0, 1);
    t_txirq(8'h01, 1'b0, 0);
    t_txirq(8'h01, 1'b1, 1);
    t_eom();
    t_rxdata();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
